// [hdl/capture_compare_consts.svh]
/*
  register offsets, field positions, mode codes and reset values of the
  capture/compare/pwm channel. assumes inclusion by its bare name.
*/
`ifndef CAPTURE_COMPARE_CONSTS_SVH
`define CAPTURE_COMPARE_CONSTS_SVH

// ============================================================
// register byte offsets
`define CC_OFF_CONTROL 5'h00
`define CC_OFF_VALUE_LOW 5'h04
`define CC_OFF_VALUE_HIGH 5'h08
`define CC_OFF_STATUS 5'h0c
`define CC_OFF_CONFIG 5'h10

// ============================================================
// field positions
`define CC_MODE_MSB 3
`define CC_MODE_LSB 0
`define CC_DUTY_MSB 5
`define CC_DUTY_LSB 4
`define CC_FLAG_BIT 0
`define CC_TSEL_MSB 1
`define CC_TSEL_LSB 0
`define CC_PINSEL_BIT 2

// ============================================================
// mode codes
`define CC_MODE_OFF 4'h0
`define CC_MODE_TOGGLE 4'h2
`define CC_MODE_CAP_FALL 4'h4
`define CC_MODE_CAP_RISE 4'h5
`define CC_MODE_CAP_4TH 4'h6
`define CC_MODE_CAP_16TH 4'h7
`define CC_MODE_SET_HIGH 4'h8
`define CC_MODE_SET_LOW 4'h9
`define CC_MODE_SOFT_EVT 4'ha
`define CC_MODE_SPECIAL 4'hb

// ============================================================
// prescaler terminal counts
`define CC_PRESC_4TH 4'h3
`define CC_PRESC_16TH 4'hf

// ============================================================
// reset values and bus answers
`define CC_RST_CONTROL 8'h00
`define CC_RST_VALUE 8'h00
`define CC_RST_TSEL 2'h0
`define CC_RST_PINSEL 1'h1
`define CC_RESP_OKAY 2'h0
`define CC_RESP_SLVERR 2'h2

`endif

// [hdl/capture_compare_pkg.sv]
/*
  types of the capture/compare/pwm channel: the state record.
  assumes capture_compare_consts.svh on the include path.
*/
`include "capture_compare_consts.svh"

package capture_compare_pkg;

  // ============================================================
  // whole state of the channel
  typedef struct packed {
    logic [7:0] control;
    logic [7:0] value_low;
    logic [7:0] value_high;
    logic flag;
    logic [1:0] timer_sel;
    logic pin_sel;
    logic pin_meta;
    logic pin_sync;
    logic pin_prev;
    logic [3:0] presc;
    logic cmp_out;
    logic match_prev;
    logic [9:0] duty_live;
    logic pwm_out;
    logic pin_val;
    logic default_en;
    logic alternate_en;
    logic clr_first;
    logic clr_third;
    logic start_conv;
    logic aw_held;
    logic [4:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } core_state_t;

endpackage : capture_compare_pkg

// [hdl/capture_compare_pwm_mode_core.sv]
/*
  one capture/compare/pwm channel with an axi4-lite register slave.
  assumes shared timers counted outside, synchronous to aclk, and port
  logic that uses the channel drive only while its drive enable is high.
*/
// Summary of operation
// - control bits 7-6 read zero, ignore writes
// - control bits 5-4 are pwm duty low bits
// - mode 0000 disables channel, resets internal state
// - mode 0010 toggles output on match, flags
// - modes 0100-0111 capture falling, rising, 4th, 16th
// - mode 1000 starts low, match forces high
// - mode 1001 starts high, match forces low
// - mode 1010 flags match, pin follows port latch
// - mode 1011 flags, clears timer, second starts conversion
// - modes 11xx are pwm on period timer
// - low and high value halves read/write
// - capture/compare uses first or third timer
// - channels run together, share or split timers
// - pwm channels share period timer event
// - capture copies selected 16-bit timer into value
// - capture sets flag, only software clears it
// - new capture overwrites value, no overrun
// - pin select routes second channel, 1 default
// - capture sees pin level even when driven
// - special event clears own timer, conversion second only
// - timer select 1x third, 01 split, 00 first
// - prescaler cleared when off or not capturing
`timescale 1ns/1ps
`default_nettype none
`include "capture_compare_consts.svh"

module capture_compare_pwm_mode_core #(
  parameter int CHANNEL_INDEX = 0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [4:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [4:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic [15:0] first_timer,
  input wire logic [15:0] third_timer,
  input wire logic [7:0] period_timer,
  input wire logic [1:0] period_timer_fraction,
  input wire logic period_event,
  input wire logic default_pin_in,
  input wire logic alternate_pin_in,
  output logic default_pin_out,
  output logic default_pin_drive,
  output logic alternate_pin_out,
  output logic alternate_pin_drive,
  output logic channel_event_flag,
  output logic use_third_timer,
  output logic clear_first_timer,
  output logic clear_third_timer,
  output logic start_conversion
);

  // ============================================================
  // helpers
  function automatic logic is_capture(input logic [3:0] m);
    return m[3:2] == 2'b01;
  endfunction : is_capture

  function automatic logic is_compare(input logic [3:0] m);
    return (m == `CC_MODE_TOGGLE) || (m[3:2] == 2'b10);
  endfunction : is_compare

  function automatic logic is_pwm(input logic [3:0] m);
    return m[3:2] == 2'b11;
  endfunction : is_pwm

  function automatic logic [33:0] read_word(input logic [4:0] a, input capture_compare_pkg::core_state_t s);
    case (a)
      `CC_OFF_CONTROL: read_word = {`CC_RESP_OKAY, 24'h0, 2'b00, s.control[5:0]};
      `CC_OFF_VALUE_LOW: read_word = {`CC_RESP_OKAY, 24'h0, s.value_low};
      `CC_OFF_VALUE_HIGH: read_word = {`CC_RESP_OKAY, 24'h0, s.value_high};
      `CC_OFF_STATUS: read_word = {`CC_RESP_OKAY, 31'h0, s.flag};
      `CC_OFF_CONFIG: read_word = {`CC_RESP_OKAY, 29'h0, s.pin_sel, s.timer_sel};
      default: read_word = {`CC_RESP_SLVERR, 32'h0};
    endcase
  endfunction : read_word

  // ============================================================
  // state
  capture_compare_pkg::core_state_t st;
  capture_compare_pkg::core_state_t next_st;

  logic [3:0] mode;
  logic third_sel;
  logic [15:0] time_base;
  logic pin_raw;
  logic rise;
  logic fall;
  logic cap_hit;
  logic match;
  logic match_rise;
  logic do_write;
  logic [33:0] rd_word;

  assign mode = st.control[`CC_MODE_MSB:`CC_MODE_LSB];
  assign third_sel = st.timer_sel[1] | ((st.timer_sel == 2'b01) && (CHANNEL_INDEX == 1));
  assign time_base = third_sel ? third_timer : first_timer;
  assign pin_raw = ((CHANNEL_INDEX == 1) && !st.pin_sel) ? alternate_pin_in : default_pin_in;
  assign rise = st.pin_sync & ~st.pin_prev;
  assign fall = ~st.pin_sync & st.pin_prev;
  assign cap_hit = ((mode == `CC_MODE_CAP_FALL) && fall) || ((mode == `CC_MODE_CAP_RISE) && rise)
    || ((mode == `CC_MODE_CAP_4TH) && rise && (st.presc == `CC_PRESC_4TH))
    || ((mode == `CC_MODE_CAP_16TH) && rise && (st.presc == `CC_PRESC_16TH));
  assign match = is_compare(mode) && (time_base == {st.value_high, st.value_low});
  assign match_rise = match && !st.match_prev;
  assign do_write = st.aw_held && st.w_held && !st.bvalid;
  assign rd_word = read_word(araddr, st);

  // ============================================================
  // next state
  always_comb begin
    next_st = st;
    next_st.pin_meta = pin_raw;
    next_st.pin_sync = st.pin_meta;
    next_st.pin_prev = st.pin_sync;
    next_st.match_prev = match;
    next_st.clr_first = 1'b0;
    next_st.clr_third = 1'b0;
    next_st.start_conv = 1'b0;

    // bus handshakes
    if (awvalid && !st.aw_held) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = awaddr;
    end
    if (wvalid && !st.w_held) begin
      next_st.w_held = 1'b1;
      next_st.w_data = wdata;
      next_st.w_strb = wstrb;
    end
    if (st.bvalid && bready) begin
      next_st.bvalid = 1'b0;
    end
    if (st.rvalid && rready) begin
      next_st.rvalid = 1'b0;
    end
    if (arvalid && !st.rvalid) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = rd_word[31:0];
      next_st.rresp = rd_word[33:32];
    end

    // software writes
    if (do_write) begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = `CC_RESP_OKAY;
      case (st.aw_addr)
        `CC_OFF_CONTROL: begin
          if (st.w_strb[0]) begin
            next_st.control = {2'b00, st.w_data[5:0]};
            if (st.w_data[3:0] == `CC_MODE_SET_HIGH) begin
              next_st.cmp_out = 1'b0;
            end
            if (st.w_data[3:0] == `CC_MODE_SET_LOW) begin
              next_st.cmp_out = 1'b1;
            end
          end
        end
        `CC_OFF_VALUE_LOW: begin
          if (st.w_strb[0]) begin
            next_st.value_low = st.w_data[7:0];
          end
        end
        `CC_OFF_VALUE_HIGH: begin
          if (st.w_strb[0]) begin
            next_st.value_high = st.w_data[7:0];
          end
        end
        `CC_OFF_STATUS: begin
          if (st.w_strb[0] && !st.w_data[`CC_FLAG_BIT]) begin
            next_st.flag = 1'b0;
          end
        end
        `CC_OFF_CONFIG: begin
          if (st.w_strb[0]) begin
            next_st.timer_sel = st.w_data[`CC_TSEL_MSB:`CC_TSEL_LSB];
            next_st.pin_sel = st.w_data[`CC_PINSEL_BIT];
          end
        end
        default: begin
          next_st.bresp = `CC_RESP_SLVERR;
        end
      endcase
    end

    // capture: overrides a same-cycle software write of the value
    if (is_capture(mode)) begin
      if (rise && ((mode == `CC_MODE_CAP_4TH) || (mode == `CC_MODE_CAP_16TH))) begin
        next_st.presc = cap_hit ? 4'h0 : 4'(st.presc + 4'h1);
      end
    end else begin
      next_st.presc = 4'h0;
    end
    if (cap_hit) begin
      next_st.value_low = time_base[7:0];
      next_st.value_high = time_base[15:8];
      next_st.flag = 1'b1;
    end

    // compare
    if (match_rise) begin
      next_st.flag = 1'b1;
      case (mode)
        `CC_MODE_TOGGLE: next_st.cmp_out = ~st.cmp_out;
        `CC_MODE_SET_HIGH: next_st.cmp_out = 1'b1;
        `CC_MODE_SET_LOW: next_st.cmp_out = 1'b0;
        `CC_MODE_SPECIAL: begin
          next_st.clr_first = !third_sel;
          next_st.clr_third = third_sel;
          next_st.start_conv = (CHANNEL_INDEX == 1);
        end
        default: begin
        end
      endcase
    end

    // pwm on the shared period timer
    if (is_pwm(mode)) begin
      if (period_event) begin
        next_st.duty_live = {st.value_low, st.control[`CC_DUTY_MSB:`CC_DUTY_LSB]};
        next_st.pwm_out = ({st.value_low, st.control[`CC_DUTY_MSB:`CC_DUTY_LSB]} != 10'h000);
      end else if ({period_timer, period_timer_fraction} >= st.duty_live) begin
        next_st.pwm_out = 1'b0;
      end
    end else begin
      next_st.pwm_out = 1'b0;
      next_st.duty_live = 10'h000;
    end

    // off clears internal state
    if (next_st.control[`CC_MODE_MSB:`CC_MODE_LSB] == `CC_MODE_OFF) begin
      next_st.cmp_out = 1'b0;
      next_st.presc = 4'h0;
      next_st.pwm_out = 1'b0;
      next_st.duty_live = 10'h000;
      next_st.match_prev = 1'b0;
    end

    // pin drive: soft-event, special and capture leave the port latch in charge
    next_st.pin_val = is_pwm(mode) ? st.pwm_out : st.cmp_out;
    next_st.default_en = 1'b0;
    next_st.alternate_en = 1'b0;
    if (is_pwm(mode) || (is_compare(mode) && (mode != `CC_MODE_SOFT_EVT) && (mode != `CC_MODE_SPECIAL))) begin
      if ((CHANNEL_INDEX == 1) && !st.pin_sel) begin
        next_st.alternate_en = 1'b1;
      end else begin
        next_st.default_en = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.control <= `CC_RST_CONTROL;
      st.value_low <= `CC_RST_VALUE;
      st.value_high <= `CC_RST_VALUE;
      st.timer_sel <= `CC_RST_TSEL;
      st.pin_sel <= `CC_RST_PINSEL;
    end else begin
      st <= next_st;
    end
  end

  // ============================================================
  // outputs
  assign awready = !st.aw_held;
  assign wready = !st.w_held;
  assign bvalid = st.bvalid;
  assign bresp = st.bresp;
  assign arready = !st.rvalid;
  assign rvalid = st.rvalid;
  assign rdata = st.rdata;
  assign rresp = st.rresp;
  assign default_pin_out = st.pin_val;
  assign default_pin_drive = st.default_en;
  assign alternate_pin_out = st.pin_val;
  assign alternate_pin_drive = st.alternate_en;
  assign channel_event_flag = st.flag;
  assign use_third_timer = third_sel;
  assign clear_first_timer = st.clr_first;
  assign clear_third_timer = st.clr_third;
  assign start_conversion = st.start_conv;

  // ============================================================
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  upper_bits_zero_a: assert property (st.control[7:6] == 2'b00) else $error("control upper bits set");
  off_state_clear_a: assert property (mode == `CC_MODE_OFF |-> st.presc == 4'h0 && !st.cmp_out && !st.pwm_out)
    else $error("off mode left internal state");
  toggle_on_match_a: assert property (mode == `CC_MODE_TOGGLE && match_rise |=> st.cmp_out != $past(st.cmp_out))
    else $error("toggle missed");
  capture_copies_a: assert property (cap_hit |=> {st.value_high, st.value_low} == $past(time_base) && st.flag)
    else $error("capture value wrong");
  flag_sticky_a: assert property (st.flag && !(do_write && st.aw_addr == `CC_OFF_STATUS) |=> st.flag)
    else $error("flag dropped by hardware");
  force_high_a: assert property (mode == `CC_MODE_SET_HIGH && match_rise |=> st.cmp_out ##1 default_pin_out || alternate_pin_out)
    else $error("force high missed");
  force_low_a: assert property (mode == `CC_MODE_SET_LOW && match_rise |=> !st.cmp_out) else $error("force low missed");
  special_clear_a: assert property (mode == `CC_MODE_SPECIAL && match_rise |=> (clear_first_timer ^ clear_third_timer)
    && start_conversion == (CHANNEL_INDEX == 1) ##1 !clear_first_timer && !clear_third_timer)
    else $error("special event pulse wrong");
  soft_no_drive_a: assert property (mode == `CC_MODE_SOFT_EVT [*2] |-> !default_pin_drive && !alternate_pin_drive)
    else $error("soft event mode drives pin");
  prescale_clear_a: assert property (!is_capture(mode) |=> st.presc == 4'h0) else $error("prescaler not cleared");

  rise_capture_c: cover property (mode == `CC_MODE_CAP_RISE && cap_hit);
  sixteenth_capture_c: cover property (mode == `CC_MODE_CAP_16TH && cap_hit);
  special_event_c: cover property (mode == `CC_MODE_SPECIAL && match_rise);
  pwm_period_c: cover property (is_pwm(mode) && period_event ##[1:300] !st.pwm_out);

endmodule : capture_compare_pwm_mode_core
`default_nettype wire

// [tb/pin_far_side.sv]
/*
  far-side model of the two channel pins: an external source per pin.
  assumes the channel's drive enables gate its own output value.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_far_side (
  input wire logic default_pin_out,
  input wire logic default_pin_drive,
  input wire logic alternate_pin_out,
  input wire logic alternate_pin_drive,
  input wire logic default_ext,
  input wire logic alternate_ext,
  output logic default_pin_in,
  output logic alternate_pin_in
);
  // ============================================================
  // pin level, own drive included
  assign default_pin_in = default_pin_drive ? default_pin_out : default_ext;
  assign alternate_pin_in = alternate_pin_drive ? alternate_pin_out : alternate_ext;
endmodule : pin_far_side
`default_nettype wire

// [tb/tb_top.sv]
/*
  register-level testbench of one capture/compare/pwm channel.
  assumes capture_compare_consts.svh on the include path.
*/
`timescale 1ns/1ps
`default_nettype none
`include "capture_compare_consts.svh"
module tb_top;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, period_event, default_ext, alternate_ext;
  logic awready, wready, bvalid, arready, rvalid, flag, use_third, clr1, clr3, conv;
  logic default_pin_in, alternate_pin_in, default_pin_out, default_pin_drive, alternate_pin_out, alternate_pin_drive;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_data;
  logic [1:0] bresp, rresp, fraction, rd_resp, wr_resp;
  logic [15:0] first_timer, third_timer;
  logic [7:0] period_timer;
  int bad_count, num_checks, n_clr1, n_clr3, n_conv;
  logic [3:0] cmode [5] = '{4'h2, 4'h8, 4'h9, 4'ha, 4'hb};
  logic cinit [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
  logic cfin [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
  logic cdrv [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
  capture_compare_pwm_mode_core #(.CHANNEL_INDEX(1)) dut (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .first_timer(first_timer), .third_timer(third_timer), .period_timer(period_timer),
    .period_timer_fraction(fraction), .period_event(period_event),
    .default_pin_in(default_pin_in), .alternate_pin_in(alternate_pin_in),
    .default_pin_out(default_pin_out), .default_pin_drive(default_pin_drive),
    .alternate_pin_out(alternate_pin_out), .alternate_pin_drive(alternate_pin_drive),
    .channel_event_flag(flag), .use_third_timer(use_third), .clear_first_timer(clr1),
    .clear_third_timer(clr3), .start_conversion(conv)
  );
  pin_far_side pins (
    .default_pin_out(default_pin_out), .default_pin_drive(default_pin_drive),
    .alternate_pin_out(alternate_pin_out), .alternate_pin_drive(alternate_pin_drive),
    .default_ext(default_ext), .alternate_ext(alternate_ext),
    .default_pin_in(default_pin_in), .alternate_pin_in(alternate_pin_in)
  );
  // ============================================================
  // clock and pulse counters
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (clr1 === 1'b1) n_clr1++;
    if (clr3 === 1'b1) n_clr3++;
    if (conv === 1'b1) n_conv++;
  end
  // ============================================================
  // bus and compare tasks
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask : wt
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    wr_resp = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd_data = rdata;
    rd_resp = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic rdchk(input logic [4:0] a, input logic [31:0] exp);
    rd(a);
    chk($sformatf("reg %h", a), rd_data, exp);
  endtask : rdchk
  task automatic rises(input int n);
    repeat (n) begin
      default_ext <= 1'b1;
      wt(5);
      default_ext <= 1'b0;
      wt(5);
    end
  endtask : rises
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (40000) @(posedge aclk);
    bad_count++;
    wrap_up();
  end
  // ============================================================
  // scenarios
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, period_event, default_ext, alternate_ext} = '0;
    {awaddr, araddr, wdata, fraction, first_timer, third_timer, period_timer} = '0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rdchk(`CC_OFF_CONTROL, 32'h0);
    rdchk(`CC_OFF_CONFIG, 32'h4);
    wr(`CC_OFF_CONTROL, 8'hff);
    rdchk(`CC_OFF_CONTROL, 32'h3f);
    wr(`CC_OFF_VALUE_LOW, 8'ha5);
    wr(`CC_OFF_VALUE_HIGH, 8'h5a);
    rdchk(`CC_OFF_VALUE_LOW, 32'ha5);
    rdchk(`CC_OFF_VALUE_HIGH, 32'h5a);
    rdchk(5'h14, 32'h0);
    chk("rresp", rd_resp, `CC_RESP_SLVERR);
    wr(5'h14, 8'h0);
    chk("bresp", wr_resp, `CC_RESP_SLVERR);
    wr(`CC_OFF_VALUE_LOW, 8'ha5);
    chk("bresp", wr_resp, `CC_RESP_OKAY);
    first_timer <= 16'h1234;
    third_timer <= 16'hbeef;
    for (int i = 0; i < 3; i++) begin
      wr(`CC_OFF_CONTROL, 8'h0);
      wr(`CC_OFF_CONTROL, {4'h0, `CC_MODE_CAP_RISE + 4'(i)});
      wr(`CC_OFF_STATUS, 8'h0);
      rises((i == 0) ? 0 : (i == 1) ? 3 : 15);
      rdchk(`CC_OFF_STATUS, 32'h0);
      rises(1);
      rdchk(`CC_OFF_STATUS, 32'h1);
      rdchk(`CC_OFF_VALUE_LOW, 32'h34);
      rdchk(`CC_OFF_VALUE_HIGH, 32'h12);
    end
    rises(2);
    wr(`CC_OFF_CONTROL, 8'h0);
    wr(`CC_OFF_CONTROL, {4'h0, `CC_MODE_CAP_4TH});
    wr(`CC_OFF_STATUS, 8'h0);
    rises(3);
    rdchk(`CC_OFF_STATUS, 32'h0);
    wr(`CC_OFF_CONTROL, {4'h0, `CC_MODE_CAP_FALL});
    for (int s = 0; s < 4; s++) begin
      wr(`CC_OFF_CONFIG, 8'h4 | 8'(s));
      default_ext <= 1'b1;
      wt(6);
      default_ext <= 1'b0;
      wt(6);
      chk("use_third", 32'(use_third), 32'(s != 0));
      rdchk(`CC_OFF_VALUE_HIGH, (s != 0) ? 32'hbe : 32'h12);
    end
    wr(`CC_OFF_CONFIG, 8'h4);
    wr(`CC_OFF_VALUE_LOW, 8'h10);
    wr(`CC_OFF_VALUE_HIGH, 8'h00);
    for (int i = 0; i < 5; i++) begin
      first_timer <= 16'h0;
      wr(`CC_OFF_CONTROL, 8'h0);
      wr(`CC_OFF_STATUS, 8'h0);
      wr(`CC_OFF_CONTROL, {4'h0, cmode[i]});
      wt(3);
      chk("drive", 32'(default_pin_drive), 32'(cdrv[i]));
      if (cdrv[i]) chk("out", 32'(default_pin_out), 32'(cinit[i]));
      first_timer <= 16'h0010;
      wt(5);
      if (cdrv[i]) chk("out", 32'(default_pin_out), 32'(cfin[i]));
      chk("flag", 32'(flag), 32'h1);
      rdchk(`CC_OFF_STATUS, 32'h1);
    end
    chk("clr1", 32'(n_clr1), 32'h1);
    chk("clr3", 32'(n_clr3), 32'h0);
    chk("conv", 32'(n_conv), 32'h1);
    // special event on the third timer: value meets its count
    wr(`CC_OFF_CONFIG, 8'h6);
    wr(`CC_OFF_VALUE_LOW, 8'hef);
    wr(`CC_OFF_VALUE_HIGH, 8'hbe);
    wt(3);
    chk("clr3", 32'(n_clr3), 32'h1);
    chk("clr1", 32'(n_clr1), 32'h1);
    chk("conv", 32'(n_conv), 32'h2);
    wr(`CC_OFF_CONTROL, 8'h0);
    wt(2);
    chk("drive", 32'(default_pin_drive), 32'h0);
    first_timer <= 16'h0;
    wr(`CC_OFF_CONFIG, 8'h0);
    wr(`CC_OFF_CONTROL, {4'h0, `CC_MODE_SET_LOW});
    wt(3);
    chk("alt", {alternate_pin_drive, alternate_pin_out, default_pin_drive}, 32'h6);
    wr(`CC_OFF_CONFIG, 8'h4);
    wr(`CC_OFF_VALUE_LOW, 8'h02);
    for (int m = 12; m < 16; m++) begin
      wr(`CC_OFF_CONTROL, 8'h10 | 8'(m));
      period_timer <= 8'h0;
      fraction <= 2'h0;
      period_event <= 1'b1;
      wt(1);
      period_event <= 1'b0;
      period_timer <= 8'h2;
      wt(3);
      chk("pwm", {default_pin_drive, default_pin_out}, 32'h3);
      fraction <= 2'h1;
      wt(3);
      chk("pwm", {default_pin_drive, default_pin_out}, 32'h2);
    end
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
